// file: verilog/usbpri_pkg.sv
// usbpri_pkg: register map, field positions and codes of the usb pipe response block
package usbpri_pkg;
	localparam logic [7:0] ENABLE_OFF    = 8'h40;
	localparam logic [7:0] CONTROL_OFF   = 8'h44;
	localparam logic [7:0] STATUS0_OFF   = 8'h60;
	localparam logic [7:0] READY_OFF     = 8'h64;
	localparam logic [7:0] NRDY_OFF      = 8'h68;
	localparam logic [7:0] EMPTY_OFF     = 8'h6C;
	localparam logic [7:0] CTRL_MPS_OFF  = 8'h84;
	localparam logic [7:0] CTRL_PIPE_OFF = 8'h88;
	localparam logic [7:0] PIPE_BASE_OFF = 8'h90;
	localparam int SEQ_CLEAR_BIT     = 8;
	localparam int NYET_MODE_BIT     = 4;
	localparam int VBUS_FLAG_BIT     = 15;
	localparam int RESUME_BIT        = 14;
	localparam int DEVSTATE_BIT      = 12;
	localparam int CTRLSTAGE_BIT     = 11;
	localparam int CLK_EN_BIT        = 0;
	localparam int STAGE_EN_LSB      = 8;
	localparam int SEQ_ERROR_IRQ_ENABLE_BIT          = 14;
	localparam int READY_IRQ_EN_BIT  = 15;
	localparam int EMPTY_EN_LSB      = 8;
	localparam logic [6:0] MPS_RESET = 7'h00;
	localparam logic [1:0] LINE_SE0  = 2'h0;
	localparam logic [1:0] LINE_J    = 2'h1;
	localparam logic [1:0] LINE_K    = 2'h2;
	localparam logic [1:0] RESP_NAK  = 2'h0;
	localparam logic [1:0] RESP_BUF  = 2'h1;
	localparam int CLK_PERIOD_NS     = 25;
	localparam int SEQ_CLEAR_GAP_NS  = 200;
	localparam int NRDY_CLEAR_GAP_NS = 100;
	localparam int SEQ_CLEAR_GAP_CYC = (SEQ_CLEAR_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NRDY_CLEAR_GAP_CYC = (NRDY_CLEAR_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		STAGE_IDLE      = 3'h0,
		STAGE_RD_DATA   = 3'h1,
		STAGE_RD_STATUS = 3'h2,
		STAGE_WR_DATA   = 3'h3,
		STAGE_WR_STATUS = 3'h4,
		STAGE_ND_STATUS = 3'h5,
		STAGE_SEQ_ERR   = 3'h6
	} usbpri_stage_type;
	typedef enum logic [1:0] {
		HS_ACK   = 2'h0,
		HS_NAK   = 2'h1,
		HS_NYET  = 2'h2,
		HS_STALL = 2'h3
	} usbpri_hs_type;
endpackage

// file: verilog/usbpri_top.sv
// usbpri_top: pipe handshake selection, status flags and apb register file
// Overview of operation
// - control IN sends up to max packet size, short packet when less buffered
// - control OUT packet above max packet size sets control empty/overflow flag
// - writing one to sequence clear forces DATA0; bit reads zero, bus reset ignored
// - nyet mode zero selects ACK/NYET, one gives ACK only; hs bulk OUT
// - automatic mode answers NAK when full, ACK with two packets free, else NYET
// - response field 00 NAK, 01 buffer dependent, 1x STALL
// - non-continuous single buffer, or double with CPU side busy, answers NYET
// - oversize OUT packet on pipes 1 to 4 sets response field to STALL
// - vbus change flag sets on either edge; level status always readable
// - writing zero clears vbus flag; with clock stopped writing one re-arms
// - seven interrupt sources; only ready, empty and control stage have enables
// - resume on J to K or SE0 in suspend; device state on four events
// - not-ready on token without data or space; empty on sent or oversize
// - stage flag on stage changes except auto address; setup reported unless stage is sequence error
// - control sequence errors set control response to STALL
// - control write data beyond request length is not an error
// - ready requests kept when disabled; summary clears when all ready cleared
// - per-pipe empty enable gates flag onto empty summary
// - writing zero clears not-ready flag, one ignored; software spaces clears
`timescale 1ns/1ps
`default_nettype none
module usbpri_top import usbpri_pkg::*; #(
	parameter int HS_BULK_MPS = 512,
	parameter int FS_MAX_MPS  = 64
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        vbus_in,
	input  wire logic        high_speed,
	input  wire logic        suspended,
	input  wire logic [1:0]  line_state,
	input  wire logic        bus_reset,
	input  wire logic        suspend_det,
	input  wire logic        addr_set,
	input  wire logic        config_set,
	input  wire logic        setup_done,
	input  wire logic        stage_valid,
	input  wire logic [2:0]  stage_code,
	input  wire logic        auto_addr_req,
	input  wire logic        ctrl_first,
	input  wire logic        tok_valid,
	input  wire logic [2:0]  tok_pipe,
	input  wire logic        tok_in,
	input  wire logic [10:0] tok_bytes,
	input  wire logic        tok_bulk,
	input  wire logic        tok_double,
	input  wire logic        tok_cont,
	input  wire logic        tok_cpu_empty,
	input  wire logic        rx_valid,
	input  wire logic [2:0]  rx_pipe,
	input  wire logic [10:0] rx_len,
	input  wire logic        rx_data1,
	input  wire logic [4:0]  xfer_ok,
	input  wire logic [4:0]  tx_all_sent,
	input  wire logic [4:0]  buf_ready_ev,
	output logic             hs_valid,
	output logic [1:0]       hs_code,
	output logic [6:0]       tx_len,
	output logic [3:0]       seq_toggle
);
	localparam int NP = 5;

	function automatic logic [NP-1:0] onehot(input logic [2:0] idx, input logic v);
		return v ? (NP'(1) << idx) : '0;
	endfunction

	function automatic logic [NP-1:0] clr0(input logic [NP-1:0] cur, input logic [NP-1:0] set,
		input logic wen, input logic [NP-1:0] wd);
		return set | (wen ? (cur & wd) : cur);
	endfunction

	logic [6:0]           ctrl_max_packet_size, next_mps;
	logic [NP-1:0][1:0]   resp, next_resp;
	logic [NP-1:0]        nyet_handshake_mode, next_nyet, toggle, next_toggle, seqclr;
	logic [NP-1:0]        pipe_ready_flag, next_ready, pipe_not_ready_flag, next_nrdy;
	logic [NP-1:0]        pipe_empty_overflow_flag, next_empty, pipe_ready_enable, next_ready_en;
	logic [NP-1:0]        pipe_empty_enable, next_empty_en, tok_oh, ovr_oh, nrdy_set, empty_set, w_pipe;
	logic                 internal_clock_enable, next_clk_en, seq_error_irq_enable, next_seq_error_irq_enable;
	logic                 buffer_ready_irq_enable, next_ready_irq_en;
	logic [5:0]           stage_en, next_stage_en;
	logic                 vbus_level_status, vbus_change_flag, next_vbus_flag, armed, next_armed;
	logic                 resume_flag, next_resume, device_state_flag, next_devstate;
	logic                 ctrl_stage_flag, next_ctrl_flag, buffer_empty_summary, next_buffer_empty_summary;
	logic                 buffer_ready_summary, next_buffer_ready_summary, next_hs_valid;
	logic [1:0]           prev_line, cur_resp, next_hs_code;
	logic [6:0]           next_tx_len, tok_low;
	usbpri_stage_type     ctrl_stage_code, next_stage, in_stage;
	logic                 acc, wr, w_status0, rset, vset, seq_err, over, nyet_cond;
	logic [10:0]          limit;
	logic                 next_pready, next_pslverr;
	logic [31:0]          next_prdata;

	assign tok_low = tok_bytes[6:0];

	// bus group: zero wait states, answer registered during setup
	always_comb begin
		next_pready  = psel & ~penable;
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		case (paddr)
			ENABLE_OFF:    next_prdata = {19'h0, pipe_empty_enable, 3'h0, pipe_ready_enable};
			CONTROL_OFF:   next_prdata = {16'h0, buffer_ready_irq_enable, seq_error_irq_enable, stage_en, 7'h0,
				internal_clock_enable};
			STATUS0_OFF:   next_prdata = {16'h0, vbus_change_flag, resume_flag, 1'b0, device_state_flag,
				ctrl_stage_flag, buffer_empty_summary, |pipe_not_ready_flag, buffer_ready_summary,
				vbus_level_status, 4'h0, ctrl_stage_code};
			READY_OFF:     next_prdata = {27'h0, pipe_ready_flag};
			NRDY_OFF:      next_prdata = {27'h0, pipe_not_ready_flag};
			EMPTY_OFF:     next_prdata = {27'h0, pipe_empty_overflow_flag};
			CTRL_MPS_OFF:  next_prdata = {25'h0, ctrl_max_packet_size};
			CTRL_PIPE_OFF: next_prdata = {30'h0, resp[0]};
			default: begin
				next_pslverr = psel & ~penable;
				for (int p = 1; p < NP; p++) begin
					if (paddr == PIPE_BASE_OFF + 8'(4 * (p - 1))) begin
						// sequence clear always reads zero
						next_prdata  = {23'h0, 1'b0, 3'h0, nyet_handshake_mode[p], toggle[p], 1'b0, resp[p]};
						next_pslverr = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= next_pready;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// core group
	always_comb begin
		acc       = psel & penable & pready;
		wr        = acc & pwrite;
		w_status0 = wr && paddr == STATUS0_OFF;
		for (int p = 0; p < NP; p++) begin
			w_pipe[p] = (p != 0) && wr && paddr == PIPE_BASE_OFF + 8'(4 * (p - 1));
		end
		tok_oh    = onehot(tok_pipe, tok_valid);
		limit     = high_speed ? 11'(HS_BULK_MPS) : 11'(FS_MAX_MPS);
		over      = rx_len > ((rx_pipe == 3'h0) ? {4'h0, ctrl_max_packet_size} : limit);
		ovr_oh    = onehot(rx_pipe, rx_valid & over);
		in_stage  = usbpri_stage_type'(stage_code);
		// write data beyond the request length is deliberately not checked
		seq_err   = 1'b0;
		if (tok_valid && tok_pipe == 3'h0) begin
			unique case (ctrl_stage_code)
				STAGE_RD_DATA:   seq_err = ~tok_in & ctrl_first;
				STAGE_RD_STATUS: seq_err = tok_in;
				STAGE_WR_DATA:   seq_err = tok_in & ctrl_first;
				STAGE_WR_STATUS,
				STAGE_ND_STATUS: seq_err = ~tok_in;
				STAGE_IDLE,
				STAGE_SEQ_ERR:   seq_err = 1'b0;
				default:         seq_err = 1'b0;
			endcase
		end
		if (rx_valid && rx_pipe == 3'h0) begin
			if (ctrl_stage_code == STAGE_RD_STATUS && !rx_data1) seq_err = 1'b1;
			if (ctrl_stage_code == STAGE_WR_DATA && ctrl_first && !rx_data1) seq_err = 1'b1;
		end
		next_mps          = (wr && paddr == CTRL_MPS_OFF) ? pwdata[6:0] : ctrl_max_packet_size;
		next_resp         = resp;
		next_nyet         = nyet_handshake_mode;
		next_toggle       = toggle;
		seqclr            = '0;
		if (wr && paddr == CTRL_PIPE_OFF) next_resp[0] = pwdata[1:0];
		if (seq_err) next_resp[0][1] = 1'b1;
		for (int p = 1; p < NP; p++) begin
			if (w_pipe[p]) begin
				next_resp[p] = pwdata[1:0];
				next_nyet[p] = pwdata[NYET_MODE_BIT];
			end
			seqclr[p] = w_pipe[p] & pwdata[SEQ_CLEAR_BIT];
			if (ovr_oh[p]) next_resp[p][1] = 1'b1;
			// a clear in the same cycle as a transfer wins; pipe is under NAK then
			next_toggle[p] = seqclr[p] ? 1'b0 : toggle[p] ^ xfer_ok[p];
		end
		nrdy_set          = tok_oh & {NP{tok_bytes == 11'h000}};
		empty_set         = tx_all_sent | ovr_oh;
		next_ready        = clr0(pipe_ready_flag, buf_ready_ev, wr && paddr == READY_OFF, pwdata[4:0]);
		next_nrdy         = clr0(pipe_not_ready_flag, nrdy_set, wr && paddr == NRDY_OFF, pwdata[4:0]);
		next_empty        = clr0(pipe_empty_overflow_flag, empty_set, wr && paddr == EMPTY_OFF, pwdata[4:0]);
		next_buffer_ready_summary         = (next_ready == '0) ? 1'b0 :
			buffer_ready_summary | (|(buf_ready_ev & pipe_ready_enable) & buffer_ready_irq_enable);
		next_buffer_empty_summary         = (next_empty == '0) ? 1'b0 :
			buffer_empty_summary | (|(empty_set & pipe_empty_enable));
		next_ready_en     = pipe_ready_enable;
		next_empty_en     = pipe_empty_enable;
		if (wr && paddr == ENABLE_OFF) begin
			next_ready_en = pwdata[4:0];
			next_empty_en = pwdata[EMPTY_EN_LSB +: NP];
		end
		next_clk_en       = internal_clock_enable;
		next_stage_en     = stage_en;
		next_seq_error_irq_enable         = seq_error_irq_enable;
		next_ready_irq_en = buffer_ready_irq_enable;
		if (wr && paddr == CONTROL_OFF) begin
			next_clk_en       = pwdata[CLK_EN_BIT];
			next_stage_en     = pwdata[STAGE_EN_LSB +: 6];
			next_seq_error_irq_enable         = pwdata[SEQ_ERROR_IRQ_ENABLE_BIT];
			next_ready_irq_en = pwdata[READY_IRQ_EN_BIT];
		end
		// vbus is sampled on pclk; detection while pclk itself stops is left to the pad ring
		vset           = armed & (vbus_in != vbus_level_status);
		next_vbus_flag = vset | (w_status0 ? vbus_change_flag & pwdata[VBUS_FLAG_BIT] : vbus_change_flag);
		next_armed     = armed;
		if (w_status0) next_armed = pwdata[VBUS_FLAG_BIT] | (internal_clock_enable & armed);
		rset           = suspended && prev_line == LINE_J && (line_state == LINE_K || line_state == LINE_SE0);
		next_resume    = rset | (w_status0 ? resume_flag & pwdata[RESUME_BIT] : resume_flag);
		next_devstate  = (bus_reset | suspend_det | addr_set | config_set) |
			(w_status0 ? device_state_flag & pwdata[DEVSTATE_BIT] : device_state_flag);
		next_ctrl_flag = w_status0 ? ctrl_stage_flag & pwdata[CTRLSTAGE_BIT] : ctrl_stage_flag;
		next_stage     = ctrl_stage_code;
		if (ctrl_stage_code == STAGE_SEQ_ERR) begin
			if (w_status0 && !pwdata[CTRLSTAGE_BIT]) next_stage = STAGE_IDLE;
		end else if (seq_err) begin
			next_stage = STAGE_SEQ_ERR;
			if (seq_error_irq_enable) next_ctrl_flag = 1'b1;
		end else if ((setup_done || stage_valid) && !auto_addr_req && in_stage != STAGE_SEQ_ERR) begin
			next_stage = in_stage;
			if (setup_done || stage_en[stage_code]) next_ctrl_flag = 1'b1;
		end
		// handshake selection
		cur_resp      = (tok_pipe < 3'(NP)) ? resp[tok_pipe] : RESP_NAK;
		nyet_cond     = (!tok_cont && !tok_double) || (!tok_cont && tok_double && !tok_cpu_empty) ||
			({1'b0, tok_bytes} < 12'(2 * HS_BULK_MPS));
		next_hs_valid = tok_valid;
		if (!tok_valid) next_hs_code = hs_code;
		else if (cur_resp[1]) next_hs_code = HS_STALL;
		else if (cur_resp == RESP_NAK || tok_bytes == 11'h000) next_hs_code = HS_NAK;
		else if (!tok_in && tok_pipe != 3'h0 && high_speed && tok_bulk && !nyet_handshake_mode[tok_pipe] && nyet_cond)
			next_hs_code = HS_NYET;
		else next_hs_code = HS_ACK;
		next_tx_len = tx_len;
		if (tok_valid && tok_in && tok_pipe == 3'h0)
			next_tx_len = (tok_bytes < {4'h0, ctrl_max_packet_size}) ? tok_low : ctrl_max_packet_size;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_max_packet_size     <= MPS_RESET;
			resp                     <= '0;
			nyet_handshake_mode      <= '0;
			toggle                   <= '0;
			pipe_ready_flag          <= '0;
			pipe_not_ready_flag      <= '0;
			pipe_empty_overflow_flag <= '0;
			pipe_ready_enable        <= '0;
			pipe_empty_enable        <= '0;
			internal_clock_enable    <= 1'b0;
			seq_error_irq_enable     <= 1'b0;
			buffer_ready_irq_enable  <= 1'b0;
			stage_en                 <= '0;
			vbus_level_status        <= 1'b0;
			vbus_change_flag         <= 1'b0;
			armed                    <= 1'b1;
			resume_flag              <= 1'b0;
			device_state_flag        <= 1'b0;
			ctrl_stage_flag          <= 1'b0;
			buffer_empty_summary     <= 1'b0;
			buffer_ready_summary     <= 1'b0;
			prev_line                <= LINE_SE0;
			ctrl_stage_code          <= STAGE_IDLE;
			hs_valid                 <= 1'b0;
			hs_code                  <= HS_ACK;
			tx_len                   <= 7'h00;
			seq_toggle               <= 4'h0;
		end else begin
			ctrl_max_packet_size     <= next_mps;
			resp                     <= next_resp;
			nyet_handshake_mode      <= next_nyet;
			toggle                   <= next_toggle;
			pipe_ready_flag          <= next_ready;
			pipe_not_ready_flag      <= next_nrdy;
			pipe_empty_overflow_flag <= next_empty;
			pipe_ready_enable        <= next_ready_en;
			pipe_empty_enable        <= next_empty_en;
			internal_clock_enable    <= next_clk_en;
			seq_error_irq_enable     <= next_seq_error_irq_enable;
			buffer_ready_irq_enable  <= next_ready_irq_en;
			stage_en                 <= next_stage_en;
			vbus_level_status        <= vbus_in;
			vbus_change_flag         <= next_vbus_flag;
			armed                    <= next_armed;
			resume_flag              <= next_resume;
			device_state_flag        <= next_devstate;
			ctrl_stage_flag          <= next_ctrl_flag;
			buffer_empty_summary     <= next_buffer_empty_summary;
			buffer_ready_summary     <= next_buffer_ready_summary;
			prev_line                <= line_state;
			ctrl_stage_code          <= next_stage;
			hs_valid                 <= next_hs_valid;
			hs_code                  <= next_hs_code;
			tx_len                   <= next_tx_len;
			seq_toggle               <= next_toggle[4:1];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_ctrl_in_tok;
		tok_valid && tok_pipe == 3'h0 && tok_in;
	endsequence
	sequence s_j_to_k;
		line_state == LINE_J ##1 suspended && (line_state == LINE_K || line_state == LINE_SE0);
	endsequence
	short_pkt_a: assert property (s_ctrl_in_tok |=>
		tx_len == (($past(tok_bytes) < {4'h0, $past(ctrl_max_packet_size)}) ? $past(tok_low) : $past(ctrl_max_packet_size)))
		else $error("control tx length wrong");
	ctrl_ovr_a: assert property (rx_valid && rx_pipe == 3'h0 && rx_len > {4'h0, ctrl_max_packet_size}
		|=> pipe_empty_overflow_flag[0]) else $error("control overflow not flagged");
	seq_clear_a: assert property (seqclr[1] |=> !toggle[1] && seq_toggle[0] == 1'b0)
		else $error("sequence clear ignored");
	stall_resp_a: assert property (tok_valid && tok_pipe < 3'h5 && resp[tok_pipe][1] |=> hs_valid && hs_code == HS_STALL)
		else $error("stall not answered");
	nak_full_a: assert property (tok_valid && tok_pipe != 3'h0 && tok_pipe < 3'h5 && !resp[tok_pipe][1]
		&& tok_bytes == 11'h000 |=> hs_code == HS_NAK) else $error("full buffer not refused");
	oversize_stall_a: assert property (rx_valid && rx_pipe == 3'h2 && rx_len > limit |=> resp[2][1] && pipe_empty_overflow_flag[2])
		else $error("oversize out packet not stalled");
	vbus_edge_a: assert property (armed && vbus_in != vbus_level_status |=> vbus_change_flag && vbus_level_status == $past(vbus_in))
		else $error("vbus edge lost");
	resume_det_a: assert property (s_j_to_k |=> resume_flag) else $error("resume not detected");
	nrdy_set_a: assert property (tok_valid && tok_pipe == 3'h3 && tok_bytes == 11'h000 |=> pipe_not_ready_flag[3])
		else $error("not ready not flagged");
	seq_hold_a: assert property (ctrl_stage_code == STAGE_SEQ_ERR && !(w_status0 && !pwdata[CTRLSTAGE_BIT])
		|=> ctrl_stage_code == STAGE_SEQ_ERR) else $error("error stage released early");
	ready_sum_a: assert property (pipe_ready_flag == '0 |-> !buffer_ready_summary) else $error("ready summary stuck");
endmodule // usbpri_top
`default_nettype wire

// file: verilog/usbpri_unused_guard.sv
// usbpri_unused_guard: intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: sim/usbpri_host.sv
// usbpri_host: host-side model issuing tokens and data packets
`timescale 1ns/1ps
`default_nettype none
module usbpri_host (
	input  wire logic        pclk,
	output var logic         tok_valid,
	output var logic [2:0]   tok_pipe,
	output var logic         tok_in,
	output var logic [10:0]  tok_bytes,
	output var logic         tok_cont,
	output var logic         rx_valid,
	output var logic [2:0]   rx_pipe,
	output var logic [10:0]  rx_len
);
	initial begin
		tok_valid = 1'b0;
		tok_pipe = 3'h0;
		tok_in = 1'b0;
		tok_bytes = 11'h000;
		tok_cont = 1'b0;
		rx_valid = 1'b0;
		rx_pipe = 3'h0;
		rx_len = 11'h000;
	end
	// released lines flip so stale values never look fresh
	task automatic token(input logic [2:0] p, input logic i, input logic [10:0] b, input logic c);
		@(posedge pclk);
		tok_valid <= 1'b1;
		{tok_pipe, tok_in, tok_bytes, tok_cont} <= {p, i, b, c};
		@(posedge pclk);
		tok_valid <= 1'b0;
		{tok_pipe, tok_in, tok_bytes, tok_cont} <= ~{p, i, b, c};
	endtask
	task automatic packet(input logic [2:0] p, input logic [10:0] n);
		@(posedge pclk);
		rx_valid <= 1'b1;
		{rx_pipe, rx_len} <= {p, n};
		@(posedge pclk);
		rx_valid <= 1'b0;
		{rx_pipe, rx_len} <= ~{p, n};
	endtask
endmodule // usbpri_host
`default_nettype wire

// file: sim/testbench.sv
// testbench: apb and host stimulus against a reference model
`timescale 1ns/1ps
`default_nettype none
module testbench import usbpri_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, vbus_in = 0, high_speed = 1;
	logic suspended = 0, bus_reset = 0, suspend_det = 0, addr_set = 0, config_set = 0, setup_done = 0;
	logic stage_valid = 0, auto_addr_req = 0, ctrl_first = 0, tok_bulk = 1, tok_double = 0;
	logic tok_cpu_empty = 1, rx_data1 = 0, pready, pslverr, hs_valid, tok_valid, tok_in, tok_cont, rx_valid;
	logic [1:0] line_state = LINE_J, hs_code;
	logic [2:0] stage_code = 0, tok_pipe, rx_pipe;
	logic [4:0] xfer_ok = 0, tx_all_sent = 0, buf_ready_ev = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [10:0] tok_bytes, rx_len;
	logic [6:0] tx_len;
	logic [3:0] seq_toggle;
	int num_errors = 0, n_checks = 0, n;
	int t_resp[8] = '{0, 2, 1, 1, 1, 1, 1, 3};
	int t_nyet[8] = '{0, 0, 0, 0, 0, 1, 0, 0};
	int t_free[8] = '{2000, 2000, 0, 1024, 1023, 600, 2000, 2000};
	int t_cont[8] = '{1, 1, 1, 1, 1, 1, 0, 1};
	always #12.5 pclk = ~pclk;
	usbpri_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.vbus_in, .high_speed, .suspended, .line_state, .bus_reset, .suspend_det, .addr_set, .config_set,
		.setup_done, .stage_valid, .stage_code, .auto_addr_req, .ctrl_first, .tok_valid, .tok_pipe, .tok_in,
		.tok_bytes, .tok_bulk, .tok_double, .tok_cont, .tok_cpu_empty, .rx_valid, .rx_pipe, .rx_len,
		.rx_data1, .xfer_ok, .tx_all_sent, .buf_ready_ev, .hs_valid, .hs_code, .tx_len, .seq_toggle);
	usbpri_host host (.pclk, .tok_valid, .tok_pipe, .tok_in, .tok_bytes, .tok_cont, .rx_valid, .rx_pipe,
		.rx_len);
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// master waits on pready only; bounded so a dead slave ends the run
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			num_errors++;
			finish_test();
		end
		rd = prdata;
		{psel, penable} <= 2'b00;
	endtask
	// reference handshake of a hi-speed bulk OUT pipe, single buffer
	function automatic int exp_hs(int resp, int nyet, int free, int cont);
		if (resp >= 2) return HS_STALL;
		if (resp == 0 || free == 0) return HS_NAK;
		if (nyet == 1 || (cont == 1 && free >= 2 * 512)) return HS_ACK;
		return HS_NYET;
	endfunction
	task automatic hs_chk(input int exp);
		#1;
		chk("hs_valid", hs_valid, 1);
		chk("hs_code", hs_code, exp);
	endtask
	initial begin
		n = $urandom(68);
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, CTRL_MPS_OFF, 0);
		chk("mps reset", rd, 0);
		apb(0, 8'h70, 0);
		chk("unmapped err", pslverr, 1);
		apb(1, CTRL_PIPE_OFF, 0);
		apb(1, CTRL_MPS_OFF, 64);
		apb(1, CTRL_PIPE_OFF, RESP_BUF);
		apb(0, CTRL_MPS_OFF, 0);
		chk("mps", rd, 64);
		for (int k = 0; k < 4; k++) begin
			n = (k == 0) ? 64 : $urandom % 127 + 1;
			host.token(0, 1, n, 0);
			#1 chk("tx_len", tx_len, (n > 64) ? 64 : n);
		end
		apb(1, ENABLE_OFF, 32'h0000_0100);
		host.packet(0, 65);
		apb(0, EMPTY_OFF, 0);
		chk("ctrl overflow", rd[0], 1);
		@(posedge pclk) buf_ready_ev <= 5'h04;
		@(posedge pclk) buf_ready_ev <= 5'h00;
		apb(0, STATUS0_OFF, 0);
		chk("empty summary", rd[10], 1);
		chk("ready disabled", rd[8], 0);
		$display("test control pipe done");
		for (int k = 0; k < 8; k++) begin
			apb(1, PIPE_BASE_OFF, 32'(t_nyet[k] * 16 + t_resp[k]));
			host.token(1, 0, t_free[k], t_cont[k]);
			hs_chk(exp_hs(t_resp[k], t_nyet[k], t_free[k], t_cont[k]));
		end
		host.token(5, 0, 100, 1);
		hs_chk(HS_NAK);
		$display("test handshake done");
		apb(1, PIPE_BASE_OFF, RESP_NAK);
		@(posedge pclk) xfer_ok <= 5'b0_0010;
		@(posedge pclk) xfer_ok <= 5'b0_0000;
		#1 chk("toggle", seq_toggle[0], 1);
		apb(1, PIPE_BASE_OFF, 32'h0000_0100);
		#1 chk("seq clear", seq_toggle[0], 0);
		apb(0, PIPE_BASE_OFF, 0);
		chk("seq clear reads", rd[SEQ_CLEAR_BIT], 0);
		@(posedge pclk) xfer_ok <= 5'b0_0010;
		bus_reset <= 1'b1;
		@(posedge pclk) {xfer_ok, bus_reset} <= 6'h00;
		#1 chk("toggle kept", seq_toggle[0], 1);
		$display("test sequence done");
		apb(1, PIPE_BASE_OFF + 4, RESP_BUF);
		apb(1, PIPE_BASE_OFF + 8, RESP_BUF);
		host.packet(2, 513);
		host.packet(3, 512);
		apb(0, PIPE_BASE_OFF + 4, 0);
		chk("oversize stall", rd[1], 1);
		apb(0, PIPE_BASE_OFF + 8, 0);
		chk("limit kept", rd[1:0], RESP_BUF);
		apb(0, EMPTY_OFF, 0);
		chk("empty flag", rd[2], 1);
		host.token(3, 0, 0, 1);
		apb(0, NRDY_OFF, 0);
		chk("not ready", rd[4:0], 5'h0A);
		apb(1, NRDY_OFF, 32'hFFFF_FFFF);
		apb(0, NRDY_OFF, 0);
		chk("nrdy one kept", rd[3], 1);
		apb(1, NRDY_OFF, 0);
		apb(0, NRDY_OFF, 0);
		chk("nrdy cleared", rd[3], 0);
		$display("test pipe status done");
		apb(1, ENABLE_OFF, 32'h0000_0110);
		apb(1, CONTROL_OFF, 32'h0000_C001);
		vbus_in <= 1'b1;
		suspended <= 1'b1;
		@(posedge pclk) line_state <= LINE_K;
		@(posedge pclk) {line_state, setup_done, stage_code, buf_ready_ev} <= {LINE_J, 1'b1, 3'h1, 5'h10};
		@(posedge pclk) {suspended, setup_done, ctrl_first, buf_ready_ev} <= {1'b0, 1'b0, 1'b1, 5'h00};
		host.token(0, 0, 64, 0);
		apb(0, STATUS0_OFF, 0);
		chk("vbus flag", rd[15], 1);
		chk("vbus level", rd[7], 1);
		chk("resume", rd[14], 1);
		chk("device state", rd[12], 1);
		chk("stage flag", rd[11], 1);
		chk("ready summary", rd[8], 1);
		chk("seq error stage", rd[2:0], 3'h6);
		apb(0, CTRL_PIPE_OFF, 0);
		chk("seq error stall", rd[1], 1);
		apb(0, READY_OFF, 0);
		chk("ready kept", rd[4:0], 5'h14);
		@(posedge pclk) setup_done <= 1'b1;
		@(posedge pclk) setup_done <= 1'b0;
		apb(0, STATUS0_OFF, 0);
		chk("stage held", rd[2:0], 3'h6);
		apb(1, STATUS0_OFF, 0);
		apb(1, READY_OFF, 0);
		apb(0, STATUS0_OFF, 0);
		chk("vbus cleared", rd[15], 0);
		chk("stage released", rd[2:0], 0);
		chk("ready summary cleared", rd[8], 0);
		apb(1, CONTROL_OFF, 0);
		apb(1, STATUS0_OFF, 0);
		vbus_in <= 1'b0;
		apb(0, STATUS0_OFF, 0);
		chk("vbus disarmed", rd[15], 0);
		apb(1, STATUS0_OFF, 32'h0000_8000);
		vbus_in <= 1'b1;
		apb(0, STATUS0_OFF, 0);
		chk("vbus rearmed", rd[15], 1);
		$display("test status done");
		finish_test();
	end
endmodule // testbench
`default_nettype wire
